// ### core/gpio_port.sv
/*
 * Eight-pin general-purpose port with AXI4-Lite register access,
 * peripheral pin override, pull-up control and standby pin blocking.
 * Assumes pins, peripheral and standby inputs are synchronous to aclk.
 */
// Our own choices: register access over AXI4-Lite and the register offsets.
`default_nettype none
module gpio_port #(
  parameter int unsigned PINS = gpio_port_pkg::PIN_COUNT
) (
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  input  wire  logic [7:0]  s_axi_awaddr,
  input  wire  logic [2:0]  s_axi_awprot,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  input  wire  logic [7:0]  s_axi_araddr,
  input  wire  logic [2:0]  s_axi_arprot,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  input  wire  logic [7:0]  pin_in,
  output logic [7:0]        pin_out,
  output logic [7:0]        pin_oe_n,
  output logic [7:0]        pin_pullup_on,
  input  wire  logic [7:0]  periph_out,
  input  wire  logic [7:0]  periph_oe,
  input  wire  logic        standby_entered,
  output logic [7:0]        periph_in,
  output logic [7:0]        ext_irq_level
);
  // Register fields are fixed at eight bits, so no other count fits
  if (PINS != gpio_port_pkg::PIN_COUNT) begin : g_pins_chk
    $error("gpio_port serves exactly eight pins");
  end

  logic [7:0] port_one_data_latch_reg;
  logic [7:0] port_one_direction_reg;
  logic [7:0] port_one_pullup_enable_reg;
  logic [1:0] standby_control_register_reg;
  logic [7:0] irq_enable_reg;
  logic [7:0] awaddr_reg;
  logic       aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic       w_held_reg;
  logic       blocking;
  logic [7:0] input_live;
  logic [7:0] drive_en;
  logic [7:0] drive_val;
  logic [7:0] gated_in;
  logic [7:0] read_normal;
  logic       do_write;
  logic [31:0] rdata_next;
  logic [1:0] rresp_next;

  // Standby blocking only when pin-state bit set
  assign blocking = standby_entered &&
    standby_control_register_reg[gpio_port_pkg::STBY_PIN_STATE_BIT];
  // Wake-capable pins with their interrupt enable bit set stay live while blocked
  assign input_live = ~{8{blocking}} | (irq_enable_reg &
    (gpio_port_pkg::SEL_IRQ_PINS | gpio_port_pkg::EXT_IRQ_PINS));
  assign gated_in = pin_in & input_live;

  always_comb begin
    drive_en  = 8'h00;
    drive_val = 8'h00;
    for (int i = 0; i < 8; i++) begin
      // Per-pin selection; no pin affects another
      if (periph_oe[i]) begin
        drive_en[i]  = 1'b1;
        drive_val[i] = periph_out[i];
      end else if (port_one_direction_reg[i]) begin
        drive_en[i]  = 1'b1;
        drive_val[i] = port_one_data_latch_reg[i];
      end
      // Open-drain pins are released instead of driving high
      if (gpio_port_pkg::OPEN_DRAIN_PINS[i] && drive_val[i]) begin
        drive_en[i] = 1'b0;
      end
      if (blocking) begin
        drive_en[i] = 1'b0;
      end
    end
  end

  // Pin stage registered so outputs come from flip-flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out       <= 8'h00;
      pin_oe_n      <= 8'hff;
      pin_pullup_on <= 8'h00;
      periph_in     <= 8'h00;
      ext_irq_level <= 8'h00;
    end else begin
      pin_out  <= drive_val;
      pin_oe_n <= ~drive_en;
      // Pull-up dropped when driving low
      pin_pullup_on <= port_one_pullup_enable_reg &
        gpio_port_pkg::PULLUP_PRESENT & ~(drive_en & ~drive_val);
      periph_in     <= gated_in;
      ext_irq_level <= gated_in;
    end
  end

  // Output pins read the latch, others read the pin
  // Peripheral-driven pins read pin level
  assign read_normal = (port_one_direction_reg & ~periph_oe &
    port_one_data_latch_reg) | ((~port_one_direction_reg | periph_oe) &
    gated_in);

  // Write channel: address and data accepted in either order
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign s_axi_awready = !aw_held_reg && aresetn;
  assign s_axi_wready  = !w_held_reg && aresetn;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= gpio_port_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      unique case (awaddr_reg & 8'hfc)
        gpio_port_pkg::DATA_LATCH_OFF, gpio_port_pkg::DIRECTION_OFF,
        gpio_port_pkg::PULLUP_OFF, gpio_port_pkg::STANDBY_CTRL_OFF,
        gpio_port_pkg::IRQ_ENABLE_OFF, gpio_port_pkg::DATA_RMW_OFF:
          s_axi_bresp <= gpio_port_pkg::RESP_OKAY;
        default: s_axi_bresp <= gpio_port_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register file; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_one_data_latch_reg <= gpio_port_pkg::DATA_LATCH_RST;
      port_one_direction_reg  <= gpio_port_pkg::DIRECTION_RST;
      port_one_pullup_enable_reg   <= gpio_port_pkg::PULLUP_RST;
      standby_control_register_reg <= gpio_port_pkg::STBY_RST;
      irq_enable_reg <= gpio_port_pkg::IRQ_ENABLE_RST;
    end else if (do_write && wstrb_reg[0]) begin
      unique case (awaddr_reg & 8'hfc)
        gpio_port_pkg::DATA_LATCH_OFF, gpio_port_pkg::DATA_RMW_OFF:
          port_one_data_latch_reg <= wdata_reg[7:0];
        gpio_port_pkg::DIRECTION_OFF:
          port_one_direction_reg <= wdata_reg[7:0];
        gpio_port_pkg::PULLUP_OFF:
          port_one_pullup_enable_reg <= wdata_reg[7:0];
        gpio_port_pkg::STANDBY_CTRL_OFF:
          standby_control_register_reg <=
            wdata_reg[gpio_port_pkg::STBY_WIDTH-1:0];
        gpio_port_pkg::IRQ_ENABLE_OFF:
          irq_enable_reg <= wdata_reg[7:0];
        default: ;
      endcase
    end
  end

  // Read path
  assign s_axi_arready = !s_axi_rvalid && aresetn;

  always_comb begin
    rdata_next = 32'h0000_0000;
    rresp_next = gpio_port_pkg::RESP_OKAY;
    unique case (s_axi_araddr & 8'hfc)
      gpio_port_pkg::DATA_LATCH_OFF:
        rdata_next[7:0] = read_normal;
      gpio_port_pkg::DATA_RMW_OFF:
        rdata_next[7:0] = port_one_data_latch_reg;
      gpio_port_pkg::DIRECTION_OFF:
        rdata_next[7:0] = port_one_direction_reg;
      gpio_port_pkg::PULLUP_OFF:
        rdata_next[7:0] = port_one_pullup_enable_reg;
      gpio_port_pkg::STANDBY_CTRL_OFF:
        rdata_next[1:0] = standby_control_register_reg;
      gpio_port_pkg::IRQ_ENABLE_OFF:
        rdata_next[7:0] = irq_enable_reg;
      default: rresp_next = gpio_port_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= gpio_port_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdata_next;
      s_axi_rresp  <= rresp_next;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Assertions
  output_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (port_one_direction_reg[2] && !periph_oe[2] && !blocking)
      |=> (!pin_oe_n[2] && pin_out[2] == $past(port_one_data_latch_reg[2])))
    else $error("output pin not driven from latch");
  input_float_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!port_one_direction_reg[4] && !periph_oe[4]) |=> pin_oe_n[4])
    else $error("input pin driven");
  periph_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (periph_oe[3] && !blocking) |=> (!pin_oe_n[3] &&
      pin_out[3] == $past(periph_out[3])))
    else $error("peripheral does not drive pin");
  standby_float_a: assert property (@(posedge aclk) disable iff (!aresetn)
    blocking |=> pin_oe_n == 8'hff)
    else $error("pins driven in standby blocking");
  standby_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (blocking && !irq_enable_reg[0]) |=> !ext_irq_level[0])
    else $error("blocked input not low");
  wake_live_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (blocking && irq_enable_reg[5]) |=> ext_irq_level[5] == $past(pin_in[5]))
    else $error("wake pin input blocked");
  pullup_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pin_oe_n[1] == 1'b0 && pin_out[1] == 1'b0) |-> !pin_pullup_on[1])
    else $error("pull-up on while driving low");
  pin_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !pin_pullup_on[0])
    else $error("pin zero pull-up active");
  reset_dir_a: assert property (@(posedge aclk)
    !aresetn |=> port_one_direction_reg == 8'h00)
    else $error("direction not cleared at reset");
  rmw_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready &&
     (s_axi_araddr & 8'hfc) == gpio_port_pkg::DATA_RMW_OFF)
      |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(port_one_data_latch_reg))
    else $error("rmw read not latch");

  // Read-back paths
  logic data_rd;
  assign data_rd = s_axi_arvalid && s_axi_arready &&
    (s_axi_araddr & 8'hfc) == gpio_port_pkg::DATA_LATCH_OFF;
  latch_read_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (data_rd && port_one_direction_reg[2] && !periph_oe[2])
      |=> s_axi_rdata[2] == $past(port_one_data_latch_reg[2]))
    else $error("output pin read not latch");
  pin_read_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (data_rd && !port_one_direction_reg[4] && !periph_oe[4] && !blocking)
      |=> s_axi_rdata[4] == $past(pin_in[4]))
    else $error("input pin read not pin level");
  periph_read_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (data_rd && periph_oe[3] && !blocking)
      |=> s_axi_rdata[3] == $past(pin_in[3]))
    else $error("peripheral pin read not pin level");
  periph_in_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !blocking
      |=> periph_in == $past(pin_in))
    else $error("peripheral input not pin level");
  irq_level_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !blocking
      |=> ext_irq_level == $past(pin_in))
    else $error("interrupt level not pin level");
  standby_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (standby_entered &&
     !standby_control_register_reg[gpio_port_pkg::STBY_PIN_STATE_BIT] &&
     port_one_direction_reg[6] && !periph_oe[6]) |=> !pin_oe_n[6])
    else $error("output released in standby with bit clear");
  // Register writes
  latch_write_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (do_write && wstrb_reg[0] &&
     (awaddr_reg & 8'hfc) == gpio_port_pkg::DATA_LATCH_OFF)
      |=> port_one_data_latch_reg == $past(wdata_reg[7:0]))
    else $error("latch write lost");
  dir_write_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (do_write && wstrb_reg[0] &&
     (awaddr_reg & 8'hfc) == gpio_port_pkg::DIRECTION_OFF)
      |=> port_one_direction_reg == $past(wdata_reg[7:0]))
    else $error("direction write lost");
  pullup_on_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (port_one_pullup_enable_reg[5] && !port_one_direction_reg[5] &&
     !periph_oe[5]) |=> pin_pullup_on[5])
    else $error("pull-up not connected");
  // Bus handshake
  write_resp_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    do_write
      |=> s_axi_bvalid)
    else $error("write response missing");
  bvalid_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready)
      |=> s_axi_bvalid)
    else $error("write response dropped");
  read_resp_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready)
      |=> s_axi_rvalid)
    else $error("read response missing");
  rvalid_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready)
      |=> s_axi_rvalid)
    else $error("read response dropped");
  rdata_upper_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid
      |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");

  write_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    do_write);
  rmw_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready &&
    (s_axi_araddr & 8'hfc) == gpio_port_pkg::DATA_RMW_OFF);
  read_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready);
  standby_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    blocking);
  periph_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    |periph_oe);
endmodule
`default_nettype wire

// ### core/gpio_port_pkg.sv
/*
 * Package for the eight-pin general-purpose port: register map, field
 * positions, reset values and the bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
`default_nettype none
package gpio_port_pkg;
  localparam int unsigned PIN_COUNT        = 8;
  localparam int unsigned ADDR_WIDTH       = 8;
  // Register byte offsets
  localparam logic [7:0]  DATA_LATCH_OFF   = 8'h00;
  localparam logic [7:0]  DIRECTION_OFF    = 8'h04;
  localparam logic [7:0]  PULLUP_OFF       = 8'h08;
  localparam logic [7:0]  STANDBY_CTRL_OFF = 8'h0c;
  localparam logic [7:0]  IRQ_ENABLE_OFF   = 8'h10;
  localparam logic [7:0]  DATA_RMW_OFF     = 8'h14;
  // Standby control fields
  localparam int unsigned STBY_PIN_STATE_BIT = 0;
  localparam int unsigned STBY_MODE_BIT      = 1;
  localparam int unsigned STBY_WIDTH         = 2;
  // Reset values
  localparam logic [7:0]  DATA_LATCH_RST   = 8'h00;
  localparam logic [7:0]  DIRECTION_RST    = 8'h00;
  localparam logic [7:0]  PULLUP_RST       = 8'h00;
  localparam logic [1:0]  STBY_RST         = 2'h0;
  localparam logic [7:0]  IRQ_ENABLE_RST   = 8'h00;
  // Pins that can wake through the pin-selection circuit: 1, 3, 5
  localparam logic [7:0]  SEL_IRQ_PINS     = 8'h2a;
  // Pins with the dedicated external interrupt lines eight, nine: 7, 6
  localparam logic [7:0]  EXT_IRQ_PINS     = 8'hc0;
  // Pins with open-drain output stage; none by default
  localparam logic [7:0]  OPEN_DRAIN_PINS  = 8'h00;
  // Pins with pull-up hardware; pin 0 has none
  localparam logic [7:0]  PULLUP_PRESENT   = 8'hfe;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage
`default_nettype wire

// ### tb/gpio_pin_model.sv
/*
 * Model of the eight package pins seen from outside the port block.
 * Assumes the bench decides per pin whether an outside driver is present.
 */
`default_nettype none
module gpio_pin_model (
  input  wire logic       aclk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] pin_pullup_on,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_level,
  output var  logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] float_q = 8'h55;
  // Open pins wander so a floating level never looks like a real value
  always_ff @(posedge aclk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_level[i];
      else if (pin_pullup_on[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_q[i];
    end
  end
endmodule
`default_nettype wire

// ### tb/eight_bit_gpio_port_one_tb_top.sv
/*
 * Self-checking bench for the eight-pin port: register bus, pin drive,
 * read-back paths, pull-ups, standby blocking and reset.
 * Assumes the design package and the pin model are compiled first.
 */
`default_nettype none
module eight_bit_gpio_port_one_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] dir, latch, pul, poe, pout, ext;
  } row_s;
  logic        aclk, aresetn, awv, wv, bry, arv, rry, awr, wr_, bv, arr, rv;
  logic        stby;
  logic [7:0]  awa, ara, pin_in, pout, oe_n, pu_on, p_out, p_oe, p_in, irq;
  logic [7:0]  ext_en, ext_lv, drv, outv, lvl, port, pu;
  logic [31:0] wd, rd;
  logic [3:0]  ws;
  logic [1:0]  br, rr;
  int          failures, n_checks;
  row_s        r;
  row_s        rows [5] = '{'{8'hff, 8'ha5, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h00, 8'h3c, 8'hff, 8'h00, 8'h00, 8'hc3},
    '{8'h0f, 8'h05, 8'hff, 8'h00, 8'h00, 8'h50},
    '{8'hf0, 8'ha0, 8'hff, 8'h18, 8'h10, 8'h07},
    '{8'h00, 8'h5a, 8'h01, 8'h81, 8'h80, 8'h0f}};
  gpio_port DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .pin_in(pin_in), .pin_out(pout), .pin_oe_n(oe_n), .pin_pullup_on(pu_on),
    .periph_out(p_out), .periph_oe(p_oe), .standby_entered(stby),
    .periph_in(p_in), .ext_irq_level(irq));
  gpio_pin_model PINS (.aclk(aclk), .pin_out(pout), .pin_oe_n(oe_n),
    .pin_pullup_on(pu_on), .ext_en(ext_en), .ext_level(ext_lv),
    .pin_in(pin_in));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk32(32'(got), 32'(exp));
  endtask
  // Handshakes sampled mid-cycle, released by the edge that took them
  task automatic wchk(input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s, input logic [1:0] exp);
    logic bh;
    int k;
    @(posedge aclk);
    awa <= a;
    wd <= {24'h00_0000, d};
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(negedge aclk);
      bh = bv;
      @(posedge aclk);
      awv <= awv && !awr;
      wv <= wv && !wr_;
      bry <= !bh;
      if (bh) break;
    end
    if (k == 50) begin
      failures++;
      results();
    end
    chk32(32'(br), 32'(exp));
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] rexp);
    logic rh;
    int k;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(negedge aclk);
      rh = rv;
      @(posedge aclk);
      arv <= arv && !arr;
      rry <= !rh;
      if (rh) break;
    end
    if (k == 50) begin
      failures++;
      results();
    end
    chk32(rd, exp);
    chk32(32'(rr), 32'(rexp));
  endtask
  task automatic settle();
    repeat (4) @(posedge aclk);
    @(negedge aclk);
  endtask
  initial begin
    {aresetn, awv, wv, bry, arv, rry, stby} = '0;
    {awa, ara, wd, ws, p_out, p_oe, ext_en, ext_lv} = '0;
    failures = 0;
    n_checks = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    chk8(oe_n, 8'hff);
    rchk(gpio_port_pkg::DIRECTION_OFF, 32'h0000_0000, 2'h0);
    foreach (rows[i]) begin
      r = rows[i];
      drv = r.dir | r.poe;
      outv = (r.poe & r.pout) | (~r.poe & r.latch);
      lvl = (drv & outv) | (~drv & r.ext);
      port = r.dir & ~r.poe;
      pu = r.pul & gpio_port_pkg::PULLUP_PRESENT & ~(drv & ~outv);
      @(posedge aclk);
      p_oe <= r.poe;
      p_out <= r.pout;
      ext_en <= ~drv;
      ext_lv <= r.ext;
      wchk(gpio_port_pkg::DATA_LATCH_OFF, r.latch, 4'hf, 2'h0);
      wchk(gpio_port_pkg::DIRECTION_OFF, r.dir, 4'hf, 2'h0);
      wchk(gpio_port_pkg::PULLUP_OFF, r.pul, 4'hf, 2'h0);
      settle();
      chk8(oe_n, ~drv);
      chk8(pout & drv, outv & drv);
      chk8(pu_on, pu);
      chk8(p_in, lvl);
      chk8(irq, lvl);
      rchk(gpio_port_pkg::DATA_LATCH_OFF, 32'((port & r.latch) |
        (~port & lvl)), 2'h0);
      rchk(gpio_port_pkg::DATA_RMW_OFF, 32'(r.latch), 2'h0);
      rchk(gpio_port_pkg::PULLUP_OFF, 32'(r.pul), 2'h0);
    end
    wchk(8'h20, 8'h77, 4'hf, gpio_port_pkg::RESP_SLVERR);
    rchk(8'h20, 32'h0000_0000, gpio_port_pkg::RESP_SLVERR);
    wchk(gpio_port_pkg::DATA_LATCH_OFF, 8'h99, 4'h0, 2'h0);
    rchk(gpio_port_pkg::DATA_RMW_OFF, 32'h0000_005a, 2'h0);
    // Standby with pin-state bit clear leaves outputs alone
    @(posedge aclk);
    p_oe <= 8'h00;
    ext_en <= 8'h00;
    stby <= 1'b1;
    wchk(gpio_port_pkg::DIRECTION_OFF, 8'hff, 4'hf, 2'h0);
    wchk(gpio_port_pkg::DATA_LATCH_OFF, 8'hc6, 4'hf, 2'h0);
    wchk(gpio_port_pkg::IRQ_ENABLE_OFF, 8'h4e, 4'hf, 2'h0);
    settle();
    chk8(oe_n, 8'h00);
    chk8(pout, 8'hc6);
    @(posedge aclk);
    ext_en <= 8'hff;
    ext_lv <= 8'hff;
    wchk(gpio_port_pkg::STANDBY_CTRL_OFF, 8'h01, 4'hf, 2'h0);
    settle();
    chk8(oe_n, 8'hff);
    chk8(p_in, 8'h4e & (gpio_port_pkg::SEL_IRQ_PINS |
      gpio_port_pkg::EXT_IRQ_PINS));
    chk8(irq, 8'h4a);
    // Reset in mid-run with every pin an output
    @(posedge aclk);
    stby <= 1'b0;
    aresetn <= 1'b0;
    settle();
    chk8(oe_n, 8'hff);
    @(posedge aclk);
    aresetn <= 1'b1;
    rchk(gpio_port_pkg::DIRECTION_OFF, 32'h0000_0000, 2'h0);
    results();
  end
endmodule
`default_nettype wire
